// [rtl/zh_plc.sv]
// Zone handoff handshake: PLC end of the link with its software port
`timescale 1ns/10ps
`default_nettype none
`include "zh_map.svh"
module zh_plc import zh_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Software port
  input  wire logic [8:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [15:0]      sw_rdata,
  // Photo sensors, blocked high
  input  wire logic        receiving_conveyor_photo_sensor,
  input  wire logic        divert_lane_photo_sensor,
  // Link to the zone controller
  zh_if.plc                lnk
);
  ////////////////////////////////////////////////////////////////////////////
  zh_plc_st_t  s_reg, s_next;
  logic        raw, go, owr;
  logic [7:0]  oaddr;
  logic [15:0] odata, nbr_up, nbr_dn;

  assign raw = sw_addr[`ZH_H_RAW] && (sw_wr || sw_rd);
  assign lnk.addr  = raw ? sw_addr[7:0] : oaddr;
  assign lnk.wdata = raw ? sw_wdata : odata;
  assign lnk.wr    = raw ? sw_wr : (go && owr);
  assign lnk.rd    = raw ? sw_rd : (go && !owr);
  assign sw_rdata  = s_reg.rsel ? lnk.rdata : s_reg.rdata;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next       = s_reg;
    go           = 1'b0;
    owr          = 1'b1;
    oaddr        = `ZH_W_ACC_UP;
    odata        = s_reg.acc_up;
    nbr_up       = s_reg.acc_up;
    nbr_dn       = s_reg.acc_dn;
    s_next.rcv_s = receiving_conveyor_photo_sensor;
    s_next.div_s = divert_lane_photo_sensor;
    s_next.rsel  = raw && sw_rd;
    s_next.rdata = 16'h0000;

    // Software access to own registers
    if (sw_wr && sw_addr == `ZH_H_CTRL)
      s_next.ctrl = sw_wdata[2:0];
    if (sw_wr && sw_addr == `ZH_H_CMD) begin
      // Neighbour hold goes to the right register
      nbr_up[`ZH_B_NBR] = s_reg.ctrl[2] ? sw_wdata[2] : s_reg.acc_up[`ZH_B_NBR];
      nbr_dn[`ZH_B_NBR] = s_reg.ctrl[2] ? s_reg.acc_dn[`ZH_B_NBR] : sw_wdata[2];
    end
    if (sw_rd && sw_addr == `ZH_H_CTRL)
      s_next.rdata = {13'h0000, s_reg.ctrl};
    if (sw_rd && sw_addr == `ZH_H_STAT)
      s_next.rdata = {10'h000, s_reg.st != H_IDLE, s_reg.mrg_p,
                      s_reg.rd_p, s_reg.ru_p, s_reg.d9c_p, s_reg.d9s_p};

    // Link sequencer, yields to raw software access
    case (s_reg.st)
      H_IDLE: begin
        go = 1'b1;
        if (s_reg.conf_p) begin
          oaddr = `ZH_W_DISCH;
          odata = `ZH_DISCH_FULL;
          if (!raw) s_next.conf_p = 1'b0;
        end else if (nbr_up != s_reg.acc_up) begin
          odata = nbr_up;
          if (!raw) s_next.acc_up = nbr_up;
        end else if (nbr_dn != s_reg.acc_dn) begin
          oaddr = `ZH_W_ACC_DN;
          odata = nbr_dn;
          if (!raw) s_next.acc_dn = nbr_dn;
        end else if (s_reg.d9s_p) begin
          odata = s_reg.acc_up | 16'h0200;
          if (!raw) begin
            s_next.acc_up = odata;
            s_next.d9s_p  = 1'b0;
          end
        end else if (s_reg.d9c_p) begin
          odata = s_reg.acc_up & 16'hfdff;
          if (!raw) begin
            s_next.acc_up = odata;
            s_next.d9c_p  = 1'b0;
            s_next.st     = H_DIV8;
          end
        end else if (s_reg.ru_p || s_reg.rd_p) begin
          owr   = 1'b0;
          oaddr = s_reg.ru_p ? `ZH_R_RCNT_UP : `ZH_R_RCNT_DN;
          if (!raw) begin
            s_next.rel_dn_sel = !s_reg.ru_p;
            s_next.st         = H_CNT;
          end
        end else if (s_reg.mrg_p) begin
          odata = s_reg.acc_up | 16'h0100;
          if (!raw) begin
            s_next.acc_up = odata;
            s_next.mrg_p  = 1'b0;
            s_next.st     = H_M12;
          end
        end else begin
          go = 1'b0;
        end
      end
      H_CNT: begin
        s_next.cnt = lnk.rdata + 16'h0001;
        s_next.st  = H_REL;
      end
      H_REL: begin
        go    = 1'b1;
        oaddr = s_reg.rel_dn_sel ? `ZH_W_REL_DN : `ZH_W_REL_UP;
        odata = s_reg.cnt;
        if (!raw) begin
          if (s_reg.rel_dn_sel) s_next.rd_p = 1'b0;
          else s_next.ru_p = 1'b0;
          s_next.st = H_IDLE;
        end
      end
      H_DIV8: begin
        go    = 1'b1;
        odata = s_reg.acc_up & 16'hfeff;
        if (!raw) begin
          s_next.acc_up = odata;
          s_next.st     = H_IDLE;
        end
      end
      H_M12: begin
        go    = 1'b1;
        odata = s_reg.acc_up | 16'h1000;
        if (!raw) begin
          s_next.acc_up = odata;
          s_next.st     = H_POLL;
        end
      end
      H_POLL: begin
        go    = 1'b1;
        owr   = 1'b0;
        oaddr = `ZH_R_STAT_UP;
        if (!raw) s_next.st = H_PWAIT;
      end
      H_PWAIT: begin
        if (lnk.rdata == `ZH_ST_OCC_STOP || lnk.rdata == `ZH_ST_OCC_RUN) begin
          go    = 1'b1;
          odata = s_reg.acc_up & 16'hefff;
          if (!raw) begin
            s_next.acc_up = odata;
            s_next.st     = H_MC8;
          end else begin
            s_next.st = H_POLL;
          end
        end else begin
          s_next.st = H_POLL;
        end
      end
      H_MC8: begin
        go    = 1'b1;
        odata = s_reg.acc_up & 16'hfeff;
        if (!raw) begin
          s_next.acc_up = odata;
          s_next.st     = H_IDLE;
        end
      end
      default: s_next.st = H_IDLE;
    endcase

    // New requests win over a service in the same cycle
    if (sw_wr && sw_addr == `ZH_H_CMD) begin
      if (sw_wdata[0]) s_next.ru_p  = 1'b1;
      if (sw_wdata[1]) s_next.rd_p  = 1'b1;
      if (sw_wdata[4]) s_next.mrg_p = 1'b1;
    end
    if (receiving_conveyor_photo_sensor && !s_reg.rcv_s && s_reg.ctrl[0])
      s_next.conf_p = 1'b1;
    if (divert_lane_photo_sensor && !s_reg.div_s && s_reg.ctrl[1])
      s_next.d9s_p = 1'b1;
    if (!divert_lane_photo_sensor && s_reg.div_s && s_reg.ctrl[1])
      s_next.d9c_p = 1'b1;

    // Raw writes keep the shadow copies current
    if (raw && sw_wr && sw_addr[7:0] == `ZH_W_ACC_UP) s_next.acc_up = sw_wdata;
    if (raw && sw_wr && sw_addr[7:0] == `ZH_W_ACC_DN) s_next.acc_dn = sw_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{st: H_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : zh_plc
`default_nettype wire

// [rtl/zh_map.svh]
// Register indices, field positions, codes and timing of the zone link
`ifndef ZH_MAP_SVH
`define ZH_MAP_SVH
// Write side of the link
`define ZH_W_ACC_UP   8'h68
`define ZH_W_ACC_DN   8'hb8
`define ZH_W_REL_UP   8'h69
`define ZH_W_REL_DN   8'hb9
`define ZH_W_DISCH    8'he8
// Read side of the link
`define ZH_R_ACC_UP   8'h68
`define ZH_R_ACC_DN   8'hb8
`define ZH_R_DISCH    8'he8
`define ZH_R_STAT_UP  8'h69
`define ZH_R_STAT_DN  8'h6a
`define ZH_R_ARR_UP   8'h6b
`define ZH_R_DEP_UP   8'h74
`define ZH_R_ARR_DN   8'hb9
`define ZH_R_DEP_DN   8'hba
`define ZH_R_RCNT_UP  8'h23
`define ZH_R_RCNT_DN  8'h58
`define ZH_R_TRK_UP1  8'hc0
`define ZH_R_TRK_UP2  8'hc1
`define ZH_R_FWD1     8'hc2
`define ZH_R_FWD2     8'hc3
`define ZH_R_FLAGS    8'hc4
// Accumulation control bits
`define ZH_B_HOLD     0
`define ZH_B_NBR      8
`define ZH_B_ARRIVED  9
`define ZH_B_WAKE     12
// Discharge status and zone status codes
`define ZH_DISCH_CLR  16'h0001
`define ZH_DISCH_FULL 16'h0005
`define ZH_ST_CLR_STOP 16'h0001
`define ZH_ST_CLR_RUN  16'h0002
`define ZH_ST_OCC_STOP 16'h0004
`define ZH_ST_OCC_RUN  16'h0005
// Host software port
`define ZH_H_CTRL     9'h000
`define ZH_H_CMD      9'h001
`define ZH_H_STAT     9'h002
`define ZH_H_RAW      8
// Timing
`define ZH_CLK_HZ     10000000
`define ZH_JAM_MS     50
`define ZH_JAM_CYC    (`ZH_JAM_MS * `ZH_CLK_HZ / 1000)
`endif

// [rtl/zh_pkg.sv]
// Types shared by both ends of the zone link
`include "zh_map.svh"
package zh_pkg;
  typedef enum logic [2:0] {
    H_IDLE, H_CNT, H_REL, H_DIV8, H_M12, H_POLL, H_PWAIT, H_MC8
  } zh_hst_t;

  typedef struct packed {
    logic [15:0] acc_up, acc_dn, disch, rel_up, rel_dn;
    logic [15:0] arr_up, dep_up, arr_dn, dep_dn;
    logic [15:0] trk_up1, trk_up2, trk_dn1, trk_dn2, fwd1, fwd2;
    logic [15:0] rdata;
    logic [23:0] jam_cnt;
    logic        rel_up_p, rel_dn_p, up_s, dn_s, wait_conf, jam, long_m;
  } zh_dev_st_t;

  typedef struct packed {
    zh_hst_t     st;
    logic [2:0]  ctrl;
    logic [15:0] acc_up, acc_dn, cnt, rdata;
    logic        conf_p, d9s_p, d9c_p, ru_p, rd_p, mrg_p, rel_dn_sel;
    logic        rsel, rcv_s, div_s;
  } zh_plc_st_t;

  function automatic logic [15:0] zh_stat(input logic occ, input logic run);
    if (occ) return run ? `ZH_ST_OCC_RUN : `ZH_ST_OCC_STOP;
    return run ? `ZH_ST_CLR_RUN : `ZH_ST_CLR_STOP;
  endfunction : zh_stat
endpackage : zh_pkg

// [rtl/zh_if.sv]
// Register link between the zone controller and the PLC
`timescale 1ns/10ps
`default_nettype none
interface zh_if;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport plc (output addr, output wdata, output wr, output rd, input rdata);
endinterface : zh_if
`default_nettype wire

// [rtl/zh_device.sv]
// Zone handoff handshake: zone controller end of the PLC link
`timescale 1ns/10ps
`default_nettype none
`include "zh_map.svh"
// Functional notes
// - Discharge status 5 blocks downstream release
// - Discharge status 1 discharges downstream carton
// - Departure loads forward tracking words
// - Missing confirm write of 5 raises jam
// - Downstream bit 8 holds upstream zone
// - Single zone uses upstream bit 8
// - Clearing bit 8 resumes automatic flow
// - Upstream bit 0 accumulates arrivals
// - Counts differ while zone occupied
// - Arrival latches current upstream tracking
// - Upstream bit 8 holds upstream neighbour
// - Bit 9 marks arrival, suppressing jam
// - Clear bit 9, then bit 8
// - Sensor blocked with bit 9: long carton
// - Status 1 when clear and stopped
// - Bit 12 wakes zone and extensions
// - Status 4 or 5 on arrival
// - Clear bit 8 after bit 12
// - Release by writing count plus one
module zh_device import zh_pkg::*; #(
  parameter int unsigned JAM_CYC = `ZH_JAM_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // PLC link
  zh_if.dev                lnk,
  // Zone sensors, blocked high
  input  wire logic        up_sensor,
  input  wire logic        dn_sensor,
  // Tracking words of a carton entering the upstream zone
  input  wire logic [15:0] trk_in1,
  input  wire logic [15:0] trk_in2,
  // Motor and neighbour controls
  output logic             up_run,
  output logic             dn_run,
  output logic             wake_ext,
  output logic             upstream_hold,
  // Conditions
  output logic             arrival_jam,
  output logic             long_carton
);
  ////////////////////////////////////////////////////////////////////////////
  if (JAM_CYC < 1 || JAM_CYC >= 2**24) begin : g_bad
    $error("JAM_CYC out of range");
  end

  zh_dev_st_t s_reg, s_next;
  logic       up_go, dn_go, conf;

  ////////////////////////////////////////////////////////////////////////////
  // Zone motion
  always_comb begin
    dn_go = dn_sensor
          && s_reg.disch == `ZH_DISCH_CLR
          && (!s_reg.acc_dn[`ZH_B_HOLD] || s_reg.rel_dn_p);
    up_go = up_sensor
          && (!dn_sensor || (s_reg.long_m && dn_go))
          && !s_reg.acc_dn[`ZH_B_NBR]
          && (!s_reg.acc_up[`ZH_B_HOLD] || s_reg.rel_up_p);
  end

  assign up_run        = up_go || s_reg.acc_up[`ZH_B_WAKE];
  assign dn_run        = dn_go || up_go;
  assign wake_ext      = s_reg.acc_up[`ZH_B_WAKE];
  assign upstream_hold = s_reg.acc_up[`ZH_B_NBR] || up_sensor;
  assign arrival_jam   = s_reg.jam;
  assign long_carton   = s_reg.long_m;
  assign lnk.rdata     = s_reg.rdata;

  // Confirmation of a downstream transfer
  assign conf = (lnk.wr && lnk.addr == `ZH_W_DISCH
                 && lnk.wdata == `ZH_DISCH_FULL)
             || s_reg.acc_up[`ZH_B_ARRIVED];

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_next      = s_reg;
    s_next.up_s = up_sensor;
    s_next.dn_s = dn_sensor;

    // Register writes hold until rewritten
    if (lnk.wr) begin
      case (lnk.addr)
        `ZH_W_ACC_UP: s_next.acc_up = lnk.wdata;
        `ZH_W_ACC_DN: s_next.acc_dn = lnk.wdata;
        `ZH_W_DISCH:  s_next.disch  = lnk.wdata;
        `ZH_W_REL_UP: begin
          if (lnk.wdata != s_reg.rel_up) begin
            s_next.rel_up   = lnk.wdata;
            s_next.rel_up_p = 1'b1;
          end
        end
        `ZH_W_REL_DN: begin
          if (lnk.wdata != s_reg.rel_dn) begin
            s_next.rel_dn   = lnk.wdata;
            s_next.rel_dn_p = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Upstream zone arrivals and departures
    if (up_sensor && !s_reg.up_s) begin
      s_next.arr_up  = s_reg.arr_up + 16'h0001;
      s_next.trk_up1 = trk_in1;
      s_next.trk_up2 = trk_in2;
    end
    if (!up_sensor && s_reg.up_s) begin
      s_next.dep_up   = s_reg.dep_up + 16'h0001;
      s_next.trk_dn1  = s_reg.trk_up1;
      s_next.trk_dn2  = s_reg.trk_up2;
      s_next.rel_up_p = 1'b0;
    end

    // Downstream zone arrivals
    if (dn_sensor && !s_reg.dn_s)
      s_next.arr_dn = s_reg.arr_dn + 16'h0001;

    // Arrival confirmation; a departure in the same cycle wins
    if (s_reg.wait_conf) begin
      if (s_reg.jam_cnt == 24'(JAM_CYC - 1))
        s_next.jam = 1'b1;
      else
        s_next.jam_cnt = s_reg.jam_cnt + 24'h000001;
    end
    if (conf) begin
      s_next.wait_conf = 1'b0;
      s_next.jam       = 1'b0;
    end
    if (!dn_sensor && s_reg.dn_s) begin
      s_next.dep_dn    = s_reg.dep_dn + 16'h0001;
      s_next.fwd1      = s_reg.trk_dn1;
      s_next.fwd2      = s_reg.trk_dn2;
      s_next.rel_dn_p  = 1'b0;
      s_next.wait_conf = 1'b1;
      s_next.jam_cnt   = 24'h000000;
    end

    // Long carton handling
    if (up_sensor && s_reg.acc_up[`ZH_B_ARRIVED])
      s_next.long_m = 1'b1;
    else if (!up_sensor && !s_reg.acc_up[`ZH_B_ARRIVED])
      s_next.long_m = 1'b0;

    // Register reads, data valid the next cycle only
    s_next.rdata = 16'h0000;
    if (lnk.rd) begin
      case (lnk.addr)
        `ZH_R_ACC_UP:  s_next.rdata = s_reg.acc_up;
        `ZH_R_ACC_DN:  s_next.rdata = s_reg.acc_dn;
        `ZH_R_DISCH:   s_next.rdata = s_reg.disch;
        `ZH_R_STAT_UP: s_next.rdata = zh_stat(up_sensor, up_run);
        `ZH_R_STAT_DN: s_next.rdata = zh_stat(dn_sensor, dn_run);
        `ZH_R_ARR_UP:  s_next.rdata = s_reg.arr_up;
        `ZH_R_DEP_UP:  s_next.rdata = s_reg.dep_up;
        `ZH_R_ARR_DN:  s_next.rdata = s_reg.arr_dn;
        `ZH_R_DEP_DN:  s_next.rdata = s_reg.dep_dn;
        `ZH_R_RCNT_UP: s_next.rdata = s_reg.rel_up;
        `ZH_R_RCNT_DN: s_next.rdata = s_reg.rel_dn;
        `ZH_R_TRK_UP1: s_next.rdata = s_reg.trk_up1;
        `ZH_R_TRK_UP2: s_next.rdata = s_reg.trk_up2;
        `ZH_R_FWD1:    s_next.rdata = s_reg.fwd1;
        `ZH_R_FWD2:    s_next.rdata = s_reg.fwd2;
        `ZH_R_FLAGS:   s_next.rdata = {13'h0000, s_reg.long_m,
                                       s_reg.jam, s_reg.wait_conf};
        default:       s_next.rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg       <= '0;
      s_reg.disch <= `ZH_DISCH_FULL;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : zh_device
`default_nettype wire

// [testbench/zh_link_properties.sv]
// Concurrent checks on the zone link and the zone pins
`timescale 1ns/10ps
`default_nettype none
`include "zh_map.svh"
module zh_link_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Link
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  // Zone pins
  input wire logic        up_sensor,
  input wire logic        dn_sensor,
  input wire logic        up_run,
  input wire logic        dn_run,
  input wire logic        upstream_hold,
  input wire logic        wake_ext,
  input wire logic        arrival_jam,
  input wire logic        long_carton
);
  logic [15:0] disch_reg, acc_up_reg, acc_dn_reg;
  ////////////////////////////////////////
  // Shadows of the written link registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      disch_reg  <= `ZH_DISCH_FULL;
      acc_up_reg <= 16'h0000;
      acc_dn_reg <= 16'h0000;
    end else if (wr) begin
      if (addr == `ZH_W_DISCH) disch_reg <= wdata;
      if (addr == `ZH_W_ACC_UP) acc_up_reg <= wdata;
      if (addr == `ZH_W_ACC_DN) acc_dn_reg <= wdata;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence conf_wr_s;
    wr && addr == `ZH_W_DISCH && wdata == `ZH_DISCH_FULL;
  endsequence
  sequence rd_disch_s;
    rd && addr == `ZH_R_DISCH;
  endsequence
  strobe_apart_a: assert property (!(wr && rd))
    else $error("link read and write together");
  rdata_idle_a: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data outside its cycle");
  disch_read_a: assert property (
    rd_disch_s |=> rdata == $past(disch_reg))
    else $error("discharge status read wrong");
  full_hold_a: assert property (
    disch_reg == `ZH_DISCH_FULL && dn_sensor |-> !dn_run)
    else $error("downstream ran while full");
  clear_run_a: assert property (
    disch_reg == `ZH_DISCH_CLR && dn_sensor && !acc_dn_reg[0]
    |-> ##[0:2] dn_run)
    else $error("downstream did not discharge");
  confirm_jam_a: assert property (conf_wr_s |=> !arrival_jam)
    else $error("jam stands after confirm");
  nbr_hold_a: assert property (acc_dn_reg[8] |-> !up_run)
    else $error("upstream zone ran while held");
  up_hold_a: assert property (acc_up_reg[8] |-> upstream_hold)
    else $error("neighbour not held");
  long_mode_a: assert property (
    up_sensor && acc_up_reg[9] |-> ##[1:3] long_carton)
    else $error("long carton mode not entered");
  wake_lvl_a: assert property (wake_ext == acc_up_reg[12])
    else $error("wake level differs from control bit");
endmodule : zh_link_properties
`default_nettype wire

// [testbench/test_zone_handoff_handshake.sv]
// Self-checking bench of the zone link with both ends joined
`timescale 1ns/10ps
`default_nettype none
`include "zh_map.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_fail++; $display("FAIL %s exp %h seen %h", nm, e, g); end end
module test_zone_handoff_handshake;
  localparam int JAM = 20;
  localparam int UP = 0, DN = 1, WK = 2, HLD = 3, JM = 4, LNG = 5;
  logic        clk, rstn, sw_wr, sw_rd, up_sensor, dn_sensor;
  logic        receiving_conveyor_photo_sensor, divert_lane_photo_sensor;
  logic [8:0]  sw_addr;
  logic [15:0] sw_wdata, sw_rdata, trk_in1, trk_in2;
  logic        up_run, dn_run, wake_ext, upstream_hold, arrival_jam;
  logic        long_carton;
  int          n_fail, n_compared;
  wire logic [5:0] outs = {long_carton, arrival_jam, upstream_hold,
                           wake_ext, dn_run, up_run};
  ////////////////////////////////////////
  zh_if lnk ();
  zh_device #(.JAM_CYC(JAM)) u_zh_device (
    .clk(clk), .rstn(rstn), .lnk(lnk), .up_sensor(up_sensor),
    .dn_sensor(dn_sensor), .trk_in1(trk_in1), .trk_in2(trk_in2),
    .up_run(up_run), .dn_run(dn_run), .wake_ext(wake_ext),
    .upstream_hold(upstream_hold), .arrival_jam(arrival_jam),
    .long_carton(long_carton));
  zh_plc u_zh_plc (
    .clk(clk), .rstn(rstn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .receiving_conveyor_photo_sensor(receiving_conveyor_photo_sensor),
    .divert_lane_photo_sensor(divert_lane_photo_sensor), .lnk(lnk));
  zh_link_properties u_zh_link_properties (
    .clk(clk), .rstn(rstn), .addr(lnk.addr), .wdata(lnk.wdata),
    .wr(lnk.wr), .rd(lnk.rd), .rdata(lnk.rdata), .up_sensor(up_sensor),
    .dn_sensor(dn_sensor), .up_run(up_run), .dn_run(dn_run),
    .upstream_hold(upstream_hold), .wake_ext(wake_ext),
    .arrival_jam(arrival_jam), .long_carton(long_carton));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic hw(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : hw
  task automatic lw(input logic [7:0] i, input logic [15:0] d);
    hw({1'b1, i}, d);
  endtask : lw
  task automatic hr(input logic [8:0] a, input logic [15:0] e,
                    input string nm);
    @(posedge clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 `CHK(nm, e, sw_rdata)
  endtask : hr
  task automatic lc(input logic [7:0] i, input logic [15:0] e,
                    input string nm);
    hr({1'b1, i}, e, nm);
  endtask : lc
  task automatic wait_lvl(input int k, input logic v, input string nm);
    #1;
    for (int i = 0; i < 60 && outs[k] !== v; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK(nm, v, outs[k])
  endtask : wait_lvl
  task automatic endt(input string nm);
    $display("test %s done", nm);
  endtask : endt
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    report_and_stop();
  end
  ////////////////////////////////////////
  initial begin
    n_fail = 0;
    n_compared = 0;
    {sw_wr, sw_rd, up_sensor, dn_sensor} = 4'h0;
    receiving_conveyor_photo_sensor = 1'b0;
    divert_lane_photo_sensor = 1'b0;
    sw_addr = 9'h000;
    sw_wdata = 16'h0000;
    trk_in1 = 16'h0000;
    trk_in2 = 16'h0000;
    rstn = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    // Reset values and an unmapped index
    lc(`ZH_R_DISCH, `ZH_DISCH_FULL, "disch");
    lc(`ZH_R_STAT_UP, `ZH_ST_CLR_STOP, "stat_up");
    lc(`ZH_R_FLAGS, 16'h0000, "flags");
    lc(8'h10, 16'h0000, "unmapped");
    endt("reset");
    // Arrival, transfer, discharge and a late confirm
    @(posedge clk);
    trk_in1   <= 16'h1234;
    trk_in2   <= 16'habcd;
    up_sensor <= 1'b1;
    repeat (4) @(posedge clk);
    lc(`ZH_R_ARR_UP, 16'h0001, "arr_up");
    lc(`ZH_R_DEP_UP, 16'h0000, "dep_up");
    lc(`ZH_R_TRK_UP1, 16'h1234, "trk_up1");
    lc(`ZH_R_TRK_UP2, 16'habcd, "trk_up2");
    lc(`ZH_R_STAT_UP, `ZH_ST_OCC_RUN, "stat_up");
    @(posedge clk) up_sensor <= 1'b0;
    repeat (4) @(posedge clk);
    lc(`ZH_R_DEP_UP, 16'h0001, "dep_up");
    @(posedge clk) dn_sensor <= 1'b1;
    repeat (4) @(posedge clk);
    #1 `CHK("dn_run", 1'b0, dn_run)
    lc(`ZH_R_STAT_DN, `ZH_ST_OCC_STOP, "stat_dn");
    lw(`ZH_W_DISCH, `ZH_DISCH_CLR);
    wait_lvl(DN, 1'b1, "dn_run");
    @(posedge clk) dn_sensor <= 1'b0;
    repeat (4) @(posedge clk);
    lc(`ZH_R_FWD1, 16'h1234, "fwd1");
    lc(`ZH_R_FWD2, 16'habcd, "fwd2");
    lc(`ZH_R_ARR_DN, 16'h0001, "arr_dn");
    lc(`ZH_R_DEP_DN, 16'h0001, "dep_dn");
    repeat (JAM) @(posedge clk);
    lc(`ZH_R_FLAGS, 16'h0003, "flags");
    hw(`ZH_H_CTRL, 16'h0001);
    @(posedge clk) receiving_conveyor_photo_sensor <= 1'b1;
    wait_lvl(JM, 1'b0, "arrival_jam");
    lc(`ZH_R_DISCH, `ZH_DISCH_FULL, "disch");
    @(posedge clk) receiving_conveyor_photo_sensor <= 1'b0;
    endt("discharge");
    // Neighbour hold in two-zone and single-zone set-ups
    hw(`ZH_H_CMD, 16'h0004);
    lc(`ZH_R_ACC_DN, 16'h0100, "acc_dn");
    @(posedge clk) up_sensor <= 1'b1;
    repeat (4) @(posedge clk);
    #1 `CHK("up_run", 1'b0, up_run)
    hw(`ZH_H_CMD, 16'h0000);
    wait_lvl(UP, 1'b1, "up_run");
    @(posedge clk) up_sensor <= 1'b0;
    hw(`ZH_H_CTRL, 16'h0005);
    hr(`ZH_H_CTRL, 16'h0005, "ctrl");
    hw(`ZH_H_CMD, 16'h0004);
    wait_lvl(HLD, 1'b1, "upstream_hold");
    lc(`ZH_R_ACC_UP, 16'h0100, "acc_up");
    hw(`ZH_H_CMD, 16'h0000);
    wait_lvl(HLD, 1'b0, "upstream_hold");
    endt("neighbour");
    // Accumulate and release by count
    hw(`ZH_H_CTRL, 16'h0000);
    lw(`ZH_W_ACC_UP, 16'h0001);
    @(posedge clk) up_sensor <= 1'b1;
    repeat (4) @(posedge clk);
    #1 `CHK("up_run", 1'b0, up_run)
    lc(`ZH_R_STAT_UP, `ZH_ST_OCC_STOP, "stat_up");
    hw(`ZH_H_CMD, 16'h0001);
    wait_lvl(UP, 1'b1, "up_run");
    lc(`ZH_R_RCNT_UP, 16'h0001, "rcnt_up");
    hw(`ZH_H_CMD, 16'h0002);
    repeat (6) @(posedge clk);
    lc(`ZH_R_RCNT_DN, 16'h0001, "rcnt_dn");
    hr(`ZH_H_STAT, 16'h0000, "plc_stat");
    @(posedge clk) up_sensor <= 1'b0;
    lw(`ZH_W_ACC_UP, 16'h0000);
    endt("release");
    // Divert arrival and long carton
    hw(`ZH_H_CTRL, 16'h0002);
    @(posedge clk) dn_sensor <= 1'b1;
    repeat (3) @(posedge clk);
    dn_sensor <= 1'b0;
    repeat (3) @(posedge clk);
    lc(`ZH_R_FLAGS, 16'h0001, "flags");
    @(posedge clk) divert_lane_photo_sensor <= 1'b1;
    repeat (4) @(posedge clk);
    lc(`ZH_R_ACC_UP, 16'h0200, "acc_up");
    lc(`ZH_R_FLAGS, 16'h0000, "flags");
    @(posedge clk) divert_lane_photo_sensor <= 1'b0;
    repeat (4) @(posedge clk);
    lc(`ZH_R_ACC_UP, 16'h0000, "acc_up");
    lw(`ZH_W_ACC_UP, 16'h0200);
    @(posedge clk) up_sensor <= 1'b1;
    wait_lvl(LNG, 1'b1, "long_carton");
    @(posedge clk) up_sensor <= 1'b0;
    lw(`ZH_W_ACC_UP, 16'h0000);
    wait_lvl(LNG, 1'b0, "long_carton");
    endt("divert");
    // Merge with wake-up
    hw(`ZH_H_CTRL, 16'h0000);
    lc(`ZH_R_STAT_UP, `ZH_ST_CLR_STOP, "stat_up");
    hw(`ZH_H_CMD, 16'h0010);
    wait_lvl(WK, 1'b1, "wake_ext");
    lc(`ZH_R_ACC_UP, 16'h1100, "acc_up");
    @(posedge clk) up_sensor <= 1'b1;
    wait_lvl(WK, 1'b0, "wake_ext");
    repeat (4) @(posedge clk);
    lc(`ZH_R_ACC_UP, 16'h0000, "acc_up");
    @(posedge clk) up_sensor <= 1'b0;
    endt("merge");
    report_and_stop();
  end
endmodule : test_zone_handoff_handshake
`default_nettype wire
